//--- src/adaptive_dead_time_offsets.sv
`timescale 1ns/1ps
module adaptive_dead_time_offsets (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] address,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [7:0] read_data,
  input wire logic [7:0] secondary_current_sense,
  input wire logic [7:0] adaptive_threshold,
  output logic offsets_active,
  output logic signed [3:0] edge1_offset_steps,
  output logic signed [3:0] edge2_offset_steps,
  output logic signed [3:0] edge3_offset_steps,
  output logic signed [3:0] edge4_offset_steps,
  output logic signed [6:0] edge1_offset_ns,
  output logic signed [6:0] edge2_offset_ns,
  output logic signed [6:0] edge3_offset_ns,
  output logic signed [6:0] edge4_offset_ns
);

  // how the block is used:
  // software programs the two dead-time registers over the plain port;
  // the sensed current and the threshold arrive on this clock every cycle;
  // the four signed offsets go on to the edge generator, which moves its
  // edges by whole 5 ns steps; this block never touches the edges itself,
  // it only decides how far each one should move and in which direction

  // stored copies of the two dead-time registers
  logic [7:0] dead_time_edges_one_two;
  logic [7:0] dead_time_edges_three_four;
  logic [7:0] next_edges_one_two;
  logic [7:0] next_edges_three_four;

  // read data is registered, so the master sees it one cycle after its strobe
  logic [7:0] next_read_data;

  // address decode, shared by the write and read paths
  logic hit_one_two;
  logic hit_three_four;
  logic write_one_two;
  logic write_three_four;
  logic read_one_two;
  logic read_three_four;

  // adaptive window flag and its next value
  logic next_active;
  logic active;

  // per-edge fields; index 0 is edge one, index 3 is edge four
  logic [3:0] pol;
  logic [dead_time_pkg::CODE_WIDTH-1:0] code [4];

  // decode once so both paths agree on which register is addressed;
  // strobes may follow each other with no gap, and never come together,
  // so a write and a read are never decoded in the same cycle
  always_comb begin
    hit_one_two = address == dead_time_pkg::ADDR_EDGES_ONE_TWO;
    hit_three_four = address == dead_time_pkg::ADDR_EDGES_THREE_FOUR;
    write_one_two = write_strobe && hit_one_two;
    write_three_four = write_strobe && hit_three_four;
    read_one_two = read_strobe && hit_one_two;
    read_three_four = read_strobe && hit_three_four;
  end

  // write path: a write to any other address leaves both registers alone
  always_comb begin
    next_edges_one_two = dead_time_edges_one_two;
    next_edges_three_four = dead_time_edges_three_four;
    if (write_one_two) begin
      next_edges_one_two = write_data;
    end
    if (write_three_four) begin
      next_edges_three_four = write_data;
    end
  end

  // both registers leave reset with every offset at zero, so edges start
  // at their nominal timing until software asks for something else;
  // a write lands at its own edge and reaches the offsets one edge later
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dead_time_edges_one_two <= dead_time_pkg::RESET_EDGES_ONE_TWO;
      dead_time_edges_three_four <= dead_time_pkg::RESET_EDGES_THREE_FOUR;
    end else begin
      dead_time_edges_one_two <= next_edges_one_two;
      dead_time_edges_three_four <= next_edges_three_four;
    end
  end

  // read path: data stands for one cycle only, then falls back to idle
  always_comb begin
    next_read_data = dead_time_pkg::READ_IDLE;
    if (read_one_two) begin
      next_read_data = dead_time_edges_one_two;
    end else if (read_three_four) begin
      next_read_data = dead_time_edges_three_four;
    end
  end

  // unmapped reads give idle too; software cannot tell a hole from a
  // register that holds zero, which is accepted to keep the port simple
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      read_data <= dead_time_pkg::READ_IDLE;
    end else begin
      read_data <= next_read_data;
    end
  end

  // adaptive window: strictly below the threshold; equal means nominal timing
  always_comb begin
    next_active = secondary_current_sense < adaptive_threshold;
  end

  // the sense code and threshold come from logic on this clock, so the
  // window needs no synchroniser; one register keeps the compare off the
  // path into the calculators, at the price of one more cycle of delay
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      active <= 1'b0;
    end else begin
      active <= next_active;
    end
  end

  assign offsets_active = active;

  // field extraction: each register carries two edges, the upper half
  // for the odd edge and the lower half for the even one, each half a
  // sign bit above a three-bit step code

  // edge one: upper half of the first register
  assign pol[0] = dead_time_edges_one_two[dead_time_pkg::POL_UPPER_BIT];
  assign code[0] = dead_time_edges_one_two[dead_time_pkg::CODE_UPPER_LSB +:
    dead_time_pkg::CODE_WIDTH];

  // edge two: lower half of the first register
  assign pol[1] = dead_time_edges_one_two[dead_time_pkg::POL_LOWER_BIT];
  assign code[1] = dead_time_edges_one_two[dead_time_pkg::CODE_LOWER_LSB +:
    dead_time_pkg::CODE_WIDTH];

  // edge three: upper half of the second register
  assign pol[2] = dead_time_edges_three_four[dead_time_pkg::POL_UPPER_BIT];
  assign code[2] = dead_time_edges_three_four[dead_time_pkg::CODE_UPPER_LSB +:
    dead_time_pkg::CODE_WIDTH];

  // edge four: lower half of the second register
  assign pol[3] = dead_time_edges_three_four[dead_time_pkg::POL_LOWER_BIT];
  assign code[3] = dead_time_edges_three_four[dead_time_pkg::CODE_LOWER_LSB +:
    dead_time_pkg::CODE_WIDTH];

  // one calculator per edge; the window flag is already registered, so
  // offsets follow the current by two cycles, traded for clean timing;
  // the offsets are handed over as signed values because a 10 ns clock
  // cannot place an edge on a 5 ns grid, the edge generator does that

  // edge one calculator
  edge_offset_if link_edge1 ();
  assign link_edge1.polarity = pol[0];
  assign link_edge1.code = code[0];
  assign link_edge1.apply = active;
  edge_offset_calc u_edge1_calc (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .port(link_edge1.calc)
  );
  assign edge1_offset_steps = link_edge1.offset_steps;
  assign edge1_offset_ns = link_edge1.offset_ns;

  // edge two calculator
  edge_offset_if link_edge2 ();
  assign link_edge2.polarity = pol[1];
  assign link_edge2.code = code[1];
  assign link_edge2.apply = active;
  edge_offset_calc u_edge2_calc (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .port(link_edge2.calc)
  );
  assign edge2_offset_steps = link_edge2.offset_steps;
  assign edge2_offset_ns = link_edge2.offset_ns;

  // edge three calculator
  edge_offset_if link_edge3 ();
  assign link_edge3.polarity = pol[2];
  assign link_edge3.code = code[2];
  assign link_edge3.apply = active;
  edge_offset_calc u_edge3_calc (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .port(link_edge3.calc)
  );
  assign edge3_offset_steps = link_edge3.offset_steps;
  assign edge3_offset_ns = link_edge3.offset_ns;

  // edge four calculator
  edge_offset_if link_edge4 ();
  assign link_edge4.polarity = pol[3];
  assign link_edge4.code = code[3];
  assign link_edge4.apply = active;
  edge_offset_calc u_edge4_calc (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .port(link_edge4.calc)
  );
  assign edge4_offset_steps = link_edge4.offset_steps;
  assign edge4_offset_ns = link_edge4.offset_ns;
endmodule

//--- src/dead_time_pkg.sv
package dead_time_pkg;
  // register byte addresses on the plain port
  localparam logic [7:0] ADDR_EDGES_ONE_TWO = 8'h69;
  localparam logic [7:0] ADDR_EDGES_THREE_FOUR = 8'h6a;
  // reset values of both registers and of the read data
  localparam logic [7:0] RESET_EDGES_ONE_TWO = 8'h00;
  localparam logic [7:0] RESET_EDGES_THREE_FOUR = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  // field positions inside a dead-time register
  localparam int POL_UPPER_BIT = 7;
  localparam int CODE_UPPER_LSB = 4;
  localparam int POL_LOWER_BIT = 3;
  localparam int CODE_LOWER_LSB = 0;
  localparam int CODE_WIDTH = 3;
  // timing of one offset code step, the largest offset and the edge count
  localparam int STEP_NS = 5;
  localparam int OFFSET_MAX_NS = 35;
  localparam int EDGE_COUNT = 4;
endpackage

//--- src/edge_offset_calc.sv
`timescale 1ns/1ps
module edge_offset_calc (
  input wire logic sys_clk,
  input wire logic reset_n,
  edge_offset_if.calc port
);
  logic signed [3:0] next_steps;
  logic signed [6:0] next_ns;
  logic signed [3:0] steps;
  logic signed [6:0] ns_val;
  logic signed [6:0] magnitude_ns;

  // signed offset: zero outside the adaptive window
  always_comb begin
    magnitude_ns = 7'(port.code * 7'(dead_time_pkg::STEP_NS));
    next_steps = 4'sd0;
    next_ns = 7'sd0;
    if (port.apply) begin
      if (port.polarity) begin
        next_steps = -$signed({1'b0, port.code});
        next_ns = -magnitude_ns;
      end else begin
        next_steps = $signed({1'b0, port.code});
        next_ns = magnitude_ns;
      end
    end
  end

  // registered so the edge generator sees a stable value per cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      steps <= 4'sd0;
      ns_val <= 7'sd0;
    end else begin
      steps <= next_steps;
      ns_val <= next_ns;
    end
  end

  assign port.offset_steps = steps;
  assign port.offset_ns = ns_val;
endmodule

//--- src/edge_offset_if.sv
`timescale 1ns/1ps
interface edge_offset_if;
  logic polarity;
  logic [2:0] code;
  logic apply;
  logic signed [3:0] offset_steps;
  logic signed [6:0] offset_ns;
  modport ctrl (output polarity, output code, output apply, input offset_steps, input offset_ns);
  modport calc (input polarity, input code, input apply, output offset_steps, output offset_ns);
endinterface

//--- tb/adaptive_dead_time_offsets_monitor.sv
`timescale 1ns/1ps
module adaptive_dead_time_offsets_monitor (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] address,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  input wire logic [7:0] secondary_current_sense,
  input wire logic [7:0] adaptive_threshold,
  input wire logic offsets_active,
  input wire logic signed [3:0] edge1_offset_steps,
  input wire logic signed [3:0] edge2_offset_steps,
  input wire logic signed [3:0] edge3_offset_steps,
  input wire logic signed [3:0] edge4_offset_steps,
  input wire logic signed [6:0] edge1_offset_ns
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // signed steps from one nibble; top bit set means the edge moves earlier
  function automatic logic signed [3:0] sv(logic [7:0] d, bit up);
    logic [3:0] h;
    h = up ? d[7:4] : d[3:0];
    return h[3] ? -$signed({1'b0, h[2:0]}) : $signed({1'b0, h[2:0]});
  endfunction
  // a write reaches the outputs two edges on, only while offsets are live
  property edge_p(a, s, up);
    write_strobe && address == a ##1 offsets_active && !write_strobe
      |=> s == sv($past(write_data, 2), up);
  endproperty
  // two edges of margin so values sampled in reset are never compared
  active_level_a: assert property ($past(reset_n, 2) |-> offsets_active ==
    $past(secondary_current_sense < adaptive_threshold)) else $error("active level wrong");
  idle_zero_a: assert property (!offsets_active |=> {edge1_offset_steps,
    edge2_offset_steps, edge3_offset_steps, edge4_offset_steps} == '0) else $error("not nominal");
  edge_one_a: assert property (edge_p(dead_time_pkg::ADDR_EDGES_ONE_TWO,
    edge1_offset_steps, 1)) else $error("edge one wrong");
  edge_two_a: assert property (edge_p(dead_time_pkg::ADDR_EDGES_ONE_TWO,
    edge2_offset_steps, 0)) else $error("edge two wrong");
  edge_three_a: assert property (edge_p(dead_time_pkg::ADDR_EDGES_THREE_FOUR,
    edge3_offset_steps, 1)) else $error("edge three wrong");
  edge_four_a: assert property (edge_p(dead_time_pkg::ADDR_EDGES_THREE_FOUR,
    edge4_offset_steps, 0)) else $error("edge four wrong");
  ns_scale_a: assert property (edge1_offset_ns ==
    edge1_offset_steps * dead_time_pkg::STEP_NS) else $error("ns scale wrong");
  cover property (offsets_active ##1 !offsets_active);
  cover property (write_strobe && address == dead_time_pkg::ADDR_EDGES_THREE_FOUR);
  cover property (edge1_offset_steps == -4'sh7);
endmodule
bind adaptive_dead_time_offsets adaptive_dead_time_offsets_monitor u_adaptive_dead_time_offsets_monitor (.*);

//--- tb/tb_adaptive_dead_time_offsets.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_adaptive_dead_time_offsets;
  logic sys_clk = 0, reset_n = 0, write_strobe = 0, read_strobe = 0, offsets_active;
  logic [7:0] address = 0, write_data = 0, read_data;
  logic [7:0] secondary_current_sense = 0, adaptive_threshold = 8'h05;
  logic signed [3:0] edge1_offset_steps, edge2_offset_steps, edge3_offset_steps, edge4_offset_steps;
  logic signed [6:0] edge1_offset_ns, edge2_offset_ns, edge3_offset_ns, edge4_offset_ns;
  int n_mismatch = 0, n_tests = 0;
  adaptive_dead_time_offsets u_adaptive_dead_time_offsets (.*);
  // free running 100 MHz clock
  initial forever #5 sys_clk = ~sys_clk;
  // one-cycle strobes, changed right after the edge
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk);
    write_strobe <= 1;
    address <= a;
    write_data <= d;
    @(posedge sys_clk);
    write_strobe <= 0;
  endtask
  task rd(logic [7:0] a, logic [7:0] e);
    @(posedge sys_clk);
    read_strobe <= 1;
    address <= a;
    @(posedge sys_clk);
    read_strobe <= 0;
    #1;
    `CHK(read_data, e)
  endtask
  // expected offset from polarity and code, in steps and in ns
  task ce(logic signed [3:0] s, logic signed [6:0] n, logic p, logic [2:0] c);
    logic signed [3:0] e;
    e = p ? -$signed({1'b0, c}) : $signed({1'b0, c});
    `CHK(s, e)
    `CHK(n, 7'(e * dead_time_pkg::STEP_NS))
  endtask
  task give_verdict;
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard
  initial begin
    #100000;
    n_mismatch++;
    give_verdict;
  end
  // every code under both signs, then the threshold boundary
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1;
    rd(dead_time_pkg::ADDR_EDGES_ONE_TWO, dead_time_pkg::RESET_EDGES_ONE_TWO);
    rd(dead_time_pkg::ADDR_EDGES_THREE_FOUR, dead_time_pkg::RESET_EDGES_THREE_FOUR);
    for (int i = 0; i < 16; i++) begin
      wr(dead_time_pkg::ADDR_EDGES_ONE_TWO, {i[3], i[2:0], ~i[3], ~i[2:0]});
      wr(dead_time_pkg::ADDR_EDGES_THREE_FOUR, {~i[3], i[2:0], i[3], ~i[2:0]});
      @(posedge sys_clk);
      #1;
      ce(edge1_offset_steps, edge1_offset_ns, i[3], i[2:0]);
      ce(edge2_offset_steps, edge2_offset_ns, ~i[3], ~i[2:0]);
      ce(edge3_offset_steps, edge3_offset_ns, ~i[3], i[2:0]);
      ce(edge4_offset_steps, edge4_offset_ns, i[3], ~i[2:0]);
    end
    wr(8'h6b, 8'hff);
    rd(8'h6b, 8'h00);
    rd(dead_time_pkg::ADDR_EDGES_ONE_TWO, 8'hf0);
    rd(dead_time_pkg::ADDR_EDGES_THREE_FOUR, 8'h78);
    // current equal to threshold must give nominal timing
    @(posedge sys_clk);
    secondary_current_sense <= 8'h05;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(offsets_active, 1'b0)
    ce(edge1_offset_steps, edge1_offset_ns, 1'b0, 3'h0);
    @(posedge sys_clk);
    secondary_current_sense <= 8'h04;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(offsets_active, 1'b1)
    ce(edge1_offset_steps, edge1_offset_ns, 1'b1, 3'h7);
    give_verdict;
  end
endmodule
